// file: front_end_control_registers.sv
`timescale 1ns/1ps
`include "front_end_defs.svh"

module front_end_control_registers
  import front_end_pkg::*;
#(
  parameter logic [3:0] DIE_VERSION = 4'h1,   // Arbitrary value
  parameter int         LINK_HALF   = `LINK_HALF_CYC
) (
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  input  wire logic            clk_en,
  input  wire logic            ctrl_cs_n,
  input  wire logic            ctrl_sclk,
  input  wire logic            ctrl_sdi,
  output logic                 ctrl_sdo,
  input  wire logic            profile_pin,
  output logic [7:0]           section_power_down,
  output logic                 sigma_delta_out,
  output logic                 general_flag_output,
  output logic [10:0]          clamp_offset,
  output rx_cfg_t              rx_cfg,
  output tx_cfg_t              tx_cfg,
  output logic [25:0]          carrier_tuning_word,
  output logic [3:0]           dac_fine_gain,
  output cable_amp_link_t      cable_amp_link
);

  // Divider must fit its counter and take at least one cycle
  initial begin
    if (LINK_HALF < 1 || LINK_HALF > 255) begin
      $error("LINK_HALF out of range");
    end
  end

  state_t st;       // Registered state
  state_t next_st;  // Next state

  // Whole bank lives in one packed struct
  // Clock enable gates only the final register
  // Helper terms below are all combinational
  // Nothing here runs on the control clock
  // Control clock is a sampled data input
  // Its edges are found against last sample
  // Host must hold each phase two cycles
  // Shorter phases can drop control bits
  // Link pins come straight from state
  // Outputs except section_power_down lag writes by one extra cycle

  // Coarse code selects one link bit
  // Code n sets bit n minus one
  // Code zero gives an empty word
  // Codes nine and up also give zero
  // Amplifier treats zero as lowest gain
  // Coarse code to link word: one bit set, code 0 and codes above 8 send zero
  function automatic logic [7:0] coarse_word(input logic [3:0] code);
    logic [7:0] w;
    w = 8'h00;
    if (code != 4'h0 && code <= 4'h8) begin
      w = 8'h01 << (code - 4'h1);
    end
    return w;
  endfunction : coarse_word

  // Read data is built once per frame
  // Loaded at the falling edge after bit eight
  // Address taken from the instruction byte
  // Revision nibble is a fixed parameter
  // Low modulator part reads back four bits
  // Upper nibble of that byte reads zero
  // Tuning bytes read back as stored
  // Gain bytes read back unmasked
  // Read mux over the register map, unmapped reads give zero
  function automatic logic [7:0] read_reg(input state_t s, input logic [4:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `OFS_POWER_DOWN:  d = s.power_down;
      `OFS_SD_FLAG:     d = s.sd_flag;
      `OFS_SD_WORD_HI:  d = s.sd_word[11:4];
      `OFS_SD_WORD_LO:  d = {4'h0, s.sd_word[3:0]};
      `OFS_CLAMP:       d = {1'b0, s.clamp};
      `OFS_ADC_CLOCK:   d = s.adc_clock;
      `OFS_DIE_VERSION: d = {4'h0, DIE_VERSION};
      `OFS_TW_LSB:      d = s.tw_lsb;
      `OFS_FINE_GAIN:   d = s.fine_gain;
      `OFS_TX_PATH:     d = s.tx_path;
      `OFS_TW0_B0:      d = s.tw0[7:0];
      `OFS_TW0_B1:      d = s.tw0[15:8];
      `OFS_TW0_B2:      d = s.tw0[23:16];
      `OFS_GAIN0:       d = s.gain0;
      `OFS_TW1_B0:      d = s.tw1[7:0];
      `OFS_TW1_B1:      d = s.tw1[15:8];
      `OFS_TW1_B2:      d = s.tw1[23:16];
      `OFS_GAIN1:       d = s.gain1;
      default:          d = 8'h00;
    endcase
    return d;
  endfunction : read_reg

  // Profile select feeds several outputs
  // Both the tuning word and the link use it
  // Pin is taken as already synchronous
  // A glitch on it would start a link send
  // Gain mode changes the link word and the fine gain source
  // Mode change itself sends nothing new
  // Helper terms of the current state
  logic       sclk_rise;    // Rising edge of control clock
  logic       sclk_fall;    // Falling edge of control clock
  logic       prof_sel;     // Active profile
  logic [7:0] active_gain;  // Gain byte of active profile
  logic [7:0] link_word;    // Word the link must carry
  logic [4:0] cmd_addr;     // Address of current frame
  logic       cmd_read;     // Frame is a read

  always_comb begin
    sclk_rise   = ctrl_sclk & ~st.sclk_prev;
    sclk_fall   = ~ctrl_sclk & st.sclk_prev;
    // Bit and pin are ORed; host keeps the unused one low
    prof_sel    = st.tx_path[`BIT_TX_PROFILE] | profile_pin;
    active_gain = prof_sel ? st.gain1 : st.gain0;
    link_word   = st.tx_path[`BIT_TX_GAIN_MODE] ? coarse_word(active_gain[7:4])
                                                : active_gain;
    // Valid once eight bits are in: instruction byte sits in the low byte
    cmd_addr    = st.shift_in[4:0];
    cmd_read    = st.shift_in[7];
  end

  // Next-state logic for the whole bank
  always_comb begin
    logic [7:0]  wdata;
    logic [12:0] sd_sum;
    logic [7:0]  rdata;
    wdata   = 8'h00;
    rdata   = 8'h00;
    sd_sum  = 13'h0000;
    next_st = st;
    next_st.sclk_prev = ctrl_sclk;

    // Frame layout: read flag, two zeros,
    // five address bits, eight data bits
    // Select high clears the bit counter
    // An aborted frame therefore stores nothing
    // Rises past the sixteenth are ignored
    // Write lands on the sixteenth rise
    // Data byte is the last eight bits in
    // Fixed-zero bits are masked on store
    // Masking costs a gate per bit, no flop
    // Unmapped offsets are dropped silently
    // Serial control port: 16-bit frames, instruction then data, MSB first
    if (ctrl_cs_n) begin
      next_st.bit_cnt = 5'h00;
    end else if (sclk_rise && st.bit_cnt < 5'(`FRAME_BITS)) begin
      next_st.shift_in = {st.shift_in[14:0], ctrl_sdi};
      next_st.bit_cnt  = st.bit_cnt + 5'h01;
      // Last data bit completes a write
      if (st.bit_cnt == 5'(`FRAME_BITS - 1) && !st.shift_in[14]) begin
        wdata = {st.shift_in[6:0], ctrl_sdi};
        // fixed-zero bits are masked, so stray ones do not stick
        case (st.shift_in[11:7])
          `OFS_POWER_DOWN: next_st.power_down = wdata;
          `OFS_SD_FLAG:    next_st.sd_flag = wdata & `MASK_SD_FLAG;
          `OFS_SD_WORD_HI: next_st.sd_word[11:4] = wdata;
          `OFS_SD_WORD_LO: next_st.sd_word[3:0] = wdata[3:0];
          `OFS_CLAMP:      next_st.clamp = wdata[6:0];
          `OFS_ADC_CLOCK:  next_st.adc_clock = wdata & `MASK_ADC_CLOCK;
          `OFS_TW_LSB:     next_st.tw_lsb = wdata & `MASK_TW_LSB;
          `OFS_FINE_GAIN:  next_st.fine_gain = wdata & `MASK_FINE_GAIN;
          `OFS_TX_PATH:    next_st.tx_path = wdata & `MASK_TX_PATH;
          `OFS_TW0_B0:     next_st.tw0[7:0] = wdata;
          `OFS_TW0_B1:     next_st.tw0[15:8] = wdata;
          `OFS_TW0_B2:     next_st.tw0[23:16] = wdata;
          `OFS_GAIN0:      next_st.gain0 = wdata;
          `OFS_TW1_B0:     next_st.tw1[7:0] = wdata;
          `OFS_TW1_B1:     next_st.tw1[15:8] = wdata;
          `OFS_TW1_B2:     next_st.tw1[23:16] = wdata;
          `OFS_GAIN1:      next_st.gain1 = wdata;
          default:         next_st.power_down = st.power_down;  // Unmapped write ignored
        endcase
      end
    end

    // Read data: loaded once the instruction is in, shifted on falling edges
    if (!ctrl_cs_n && sclk_fall) begin
      if (st.bit_cnt == 5'h08 && cmd_read) begin
        rdata             = read_reg(st, cmd_addr);
        next_st.shift_out = rdata;
        next_st.sdo       = rdata[7];
      end else if (st.bit_cnt > 5'h08) begin
        next_st.sdo       = st.shift_out[6];
        next_st.shift_out = {st.shift_out[6:0], 1'b0};
      end
    end
    if (ctrl_cs_n) begin
      next_st.sdo = 1'b0;
    end

    // Accumulator adds the word each cycle
    // Word zero gives no pulses at all
    // Word all ones gives almost all ones
    // Output is a plain flop, filter off chip
    // Fixed mode shows the word's top bit
    // Accumulator keeps running meanwhile
    // So leaving fixed mode needs no restart
    // First-order modulator; carry out is the pulse density
    sd_sum         = {1'b0, st.sd_acc} + {1'b0, st.sd_word};
    next_st.sd_acc = sd_sum[11:0];
    if (st.sd_flag[`BIT_SD_FIXED]) begin
      next_st.sd_out = st.sd_word[11];
    end else begin
      next_st.sd_out = sd_sum[12];
    end
    next_st.flag_out = st.sd_flag[`BIT_FLAG_OUT];

    // Every config output but section_power_down is one cycle late
    // Keeps outputs free of decode glitches
    // Costs a flop per bit, judged cheap
    // Clamp offset is the value times sixteen
    // Range limits are left to the host
    // Values outside still shift cleanly
    // Registered copies of configuration outputs
    next_st.clamp_offset                 = {st.clamp, 4'h0};
    next_st.rx_cfg.ten_bit_only          = st.adc_clock[`BIT_ADC_TEN_ONLY];
    next_st.rx_cfg.twelve_bit_only       = st.adc_clock[`BIT_ADC_TWELVE_ONLY];
    next_st.rx_cfg.iq_seven_bit          = st.adc_clock[`BIT_ADC_IQ_SEVEN];
    next_st.rx_cfg.iq_clk_off            = st.adc_clock[`BIT_ADC_IQ_CLK_OFF];
    next_st.rx_cfg.fast_edge             = st.adc_clock[`BIT_ADC_FAST_EDGE];
    next_st.rx_cfg.adc_clk_direct        = st.adc_clock[`BIT_ADC_CLK_DIRECT];
    next_st.tx_cfg.single_tone           = st.tx_path[`BIT_TX_SINGLE_TONE];
    next_st.tx_cfg.spectral_invert       = st.tx_path[`BIT_TX_SPEC_INV];
    next_st.tx_cfg.sinc_bypass           = st.tx_path[`BIT_TX_SINC_BYPASS];
    next_st.tx_cfg.gain_mode             = st.tx_path[`BIT_TX_GAIN_MODE];
    next_st.tx_cfg.profile_active        = prof_sel;

    // Active tuning word: three bytes above the profile's own two bits of tw_lsb
    if (prof_sel) begin
      next_st.tuning_word = {st.tw1, st.tw_lsb[3:2]};
    end else begin
      next_st.tuning_word = {st.tw0, st.tw_lsb[1:0]};
    end

    // Fine gain source depends on gain control mode
    if (st.tx_path[`BIT_TX_GAIN_MODE]) begin
      next_st.dac_gain = active_gain[3:0];
    end else begin
      next_st.dac_gain = st.fine_gain[3:0];
    end

    // Link sends one byte, top bit first
    // Data is set while the link clock is low
    // Receiver takes it on the rising edge
    // Each phase lasts LINK_HALF cycles
    // After bit zero the latch pulses once
    // Latch and clock never rise together
    // Data returns low once the latch ends
    // Idle state compares with the last sent
    // Any difference starts a fresh send
    // Several changes during a send merge
    // Only the newest value is sent after
    // Link clock idles low between words
    // Link shifter: clock low with data, clock high, eight bits, latch
    next_st.link.latch = 1'b0;
    case (st.link_st)
      LINK_IDLE: begin
        next_st.link.clk = 1'b0;
        // Difference persists until sent, so a change mid-send is not lost
        if (active_gain != st.sent_gain || prof_sel != st.sent_prof) begin
          next_st.sent_gain = active_gain;
          next_st.sent_prof = prof_sel;
          next_st.link_sh   = link_word;
          next_st.link_bit  = 3'h7;
          next_st.link_div  = 8'(LINK_HALF - 1);
          next_st.link.data = link_word[7];
          next_st.link_st   = LINK_LOW;
        end
      end
      LINK_LOW: begin
        if (st.link_div == 8'h00) begin
          next_st.link.clk = 1'b1;
          next_st.link_div = 8'(LINK_HALF - 1);
          next_st.link_st  = LINK_HIGH;
        end else begin
          next_st.link_div = st.link_div - 8'h01;
        end
      end
      LINK_HIGH: begin
        if (st.link_div == 8'h00) begin
          next_st.link.clk = 1'b0;
          next_st.link_div = 8'(LINK_HALF - 1);
          if (st.link_bit == 3'h0) begin
            next_st.link.latch = 1'b1;
            next_st.link_st    = LINK_LATCH;
          end else begin
            next_st.link_bit  = st.link_bit - 3'h1;
            next_st.link_sh   = {st.link_sh[6:0], 1'b0};
            next_st.link.data = st.link_sh[6];
            next_st.link_st   = LINK_LOW;
          end
        end else begin
          next_st.link_div = st.link_div - 8'h01;
        end
      end
      LINK_LATCH: begin
        // Latch held for one half period
        if (st.link_div == 8'h00) begin
          next_st.link.data = 1'b0;
          next_st.link_st   = LINK_IDLE;
        end else begin
          next_st.link.latch = 1'b1;
          next_st.link_div   = st.link_div - 8'h01;
        end
      end
      default: begin
        next_st.link_st = LINK_IDLE;
      end
    endcase
  end

  // Asynchronous reset, released by edge
  // Reset loads constants only
  // Clamp and the idle link state are the nonzero resets
  // Its offset copy is preset to match
  // Link shifter starts idle after reset
  // Sent gain and profile reset to zero
  // So reset itself sends no link word
  // Frozen state keeps the link mid-word
  // State register; clock enable freezes everything
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st              <= '0;
      st.clamp        <= `RST_CLAMP;
      st.clamp_offset <= {`RST_CLAMP, 4'h0};
      st.link_st      <= LINK_IDLE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Plain wires from the state struct
  // No logic between flop and pin
  // Keeps output timing predictable
  // Host read data also comes from a flop
  // Outputs straight from state
  always_comb begin
    ctrl_sdo            = st.sdo;
    section_power_down  = st.power_down;
    sigma_delta_out     = st.sd_out;
    general_flag_output = st.flag_out;
    clamp_offset        = st.clamp_offset;
    rx_cfg              = st.rx_cfg;
    tx_cfg              = st.tx_cfg;
    carrier_tuning_word = st.tuning_word;
    dac_fine_gain       = st.dac_gain;
    cable_amp_link      = st.link;
  end

endmodule : front_end_control_registers

// file: front_end_defs.svh
`ifndef FRONT_END_DEFS_SVH
`define FRONT_END_DEFS_SVH

// Register offsets
`define OFS_POWER_DOWN      5'h02
`define OFS_SD_FLAG         5'h03
`define OFS_SD_WORD_HI      5'h04
`define OFS_SD_WORD_LO      5'h05
`define OFS_CLAMP           5'h07
`define OFS_ADC_CLOCK       5'h08
`define OFS_DIE_VERSION     5'h0C
`define OFS_TW_LSB          5'h0D
`define OFS_FINE_GAIN       5'h0E
`define OFS_TX_PATH         5'h0F
`define OFS_TW0_B0          5'h10
`define OFS_TW0_B1          5'h11
`define OFS_TW0_B2          5'h12
`define OFS_GAIN0           5'h13
`define OFS_TW1_B0          5'h14
`define OFS_TW1_B1          5'h15
`define OFS_TW1_B2          5'h16
`define OFS_GAIN1           5'h17

// Field positions
`define BIT_SD_FIXED        0
`define BIT_FLAG_OUT        1
`define BIT_ADC_TEN_ONLY    0
`define BIT_ADC_TWELVE_ONLY 1
`define BIT_ADC_IQ_SEVEN    3
`define BIT_ADC_IQ_CLK_OFF  4
`define BIT_ADC_FAST_EDGE   5
`define BIT_ADC_CLK_DIRECT  7
`define BIT_TX_SINGLE_TONE  0
`define BIT_TX_SPEC_INV     1
`define BIT_TX_SINC_BYPASS  2
`define BIT_TX_GAIN_MODE    3
`define BIT_TX_PROFILE      5

// Writable bit masks (fixed-zero bits stay zero)
`define MASK_SD_FLAG        8'h03
`define MASK_ADC_CLOCK      8'hBB
`define MASK_TW_LSB         8'h0F
`define MASK_FINE_GAIN      8'h0F
`define MASK_TX_PATH        8'h2F
`define MASK_CLAMP          8'h7F

// Reset values
`define RST_ZERO            8'h00
`define RST_CLAMP           7'h20

// Timing of the cable amplifier link
`define CLK_PERIOD_NS       8
`define LINK_HALF_NS        40
`define LINK_HALF_CYC       ((`LINK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Serial control frame length in bits
`define FRAME_BITS          16

`endif

// file: front_end_pkg.sv
package front_end_pkg;

  // Link shifter states, one-hot
  typedef enum logic [3:0] {
    LINK_IDLE  = 4'b0001,
    LINK_LOW   = 4'b0010,
    LINK_HIGH  = 4'b0100,
    LINK_LATCH = 4'b1000
  } link_state_t;

  // Receive converter settings
  typedef struct packed {
    logic ten_bit_only;
    logic twelve_bit_only;
    logic iq_seven_bit;
    logic iq_clk_off;
    logic fast_edge;
    logic adc_clk_direct;
  } rx_cfg_t;

  // Transmit path settings
  typedef struct packed {
    logic single_tone;
    logic spectral_invert;
    logic sinc_bypass;
    logic gain_mode;
    logic profile_active;
  } tx_cfg_t;

  // Cable amplifier link pins
  typedef struct packed {
    logic clk;
    logic data;
    logic latch;
  } cable_amp_link_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0]      power_down;
    logic [7:0]      sd_flag;
    logic [11:0]     sd_word;
    logic [11:0]     sd_acc;
    logic            sd_out;
    logic            flag_out;
    logic [6:0]      clamp;
    logic [7:0]      adc_clock;
    logic [7:0]      tw_lsb;
    logic [7:0]      fine_gain;
    logic [7:0]      tx_path;
    logic [23:0]     tw0;
    logic [23:0]     tw1;
    logic [7:0]      gain0;
    logic [7:0]      gain1;
    logic            sclk_prev;
    logic [4:0]      bit_cnt;
    logic [15:0]     shift_in;
    logic [7:0]      shift_out;
    logic            sdo;
    link_state_t     link_st;
    logic [7:0]      link_div;
    logic [2:0]      link_bit;
    logic [7:0]      link_sh;
    cable_amp_link_t link;
    logic [7:0]      sent_gain;
    logic            sent_prof;
    logic [25:0]     tuning_word;
    logic [3:0]      dac_gain;
    logic [10:0]     clamp_offset;
    rx_cfg_t         rx_cfg;
    tx_cfg_t         tx_cfg;
  } state_t;

endpackage : front_end_pkg

// file: front_end_checker.sv
`timescale 1ns/1ps
module front_end_checker
  import front_end_pkg::*;
#(
  parameter int LINK_HALF = 5
) (
  input wire logic            ref_clk,
  input wire logic            nrst,
  input wire logic            clk_en,
  input wire logic            ctrl_cs_n,
  input wire logic            ctrl_sdo,
  input wire logic            profile_pin,
  input wire logic [10:0]     clamp_offset,
  input wire tx_cfg_t         tx_cfg,
  input wire logic [25:0]     carrier_tuning_word,
  input wire cable_amp_link_t cable_amp_link
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic [7:0] hi_cnt;   // Enabled edges with link clock high
  logic [7:0] lat_cnt;  // Enabled edges with latch high
  logic [3:0] rise_cnt; // Link clock rises since last latch
  logic       clk_q;    // Link clock at last enabled edge

  // Counters advance only on enabled edges, as the shifter does
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt   <= 8'h00;
      lat_cnt  <= 8'h00;
      rise_cnt <= 4'h0;
      clk_q    <= 1'b0;
    end else if (clk_en) begin
      hi_cnt  <= cable_amp_link.clk ? hi_cnt + 8'h01 : 8'h00;
      lat_cnt <= cable_amp_link.latch ? lat_cnt + 8'h01 : 8'h00;
      clk_q   <= cable_amp_link.clk;
      // Fresh count for every word
      if (cable_amp_link.latch) begin
        rise_cnt <= 4'h0;
      end else if (cable_amp_link.clk && !clk_q) begin
        rise_cnt <= rise_cnt + 4'h1;
      end
    end
  end

  a_clamp_scaled: assert property (clamp_offset[3:0] == 4'h0)
    else $error("clamp offset not a multiple of sixteen");
  a_sdo_quiet: assert property (ctrl_cs_n && $past(ctrl_cs_n) |-> !ctrl_sdo)
    else $error("read data driven while port deselected");
  a_data_steady: assert property (cable_amp_link.clk && $past(cable_amp_link.clk) |-> $stable(cable_amp_link.data))
    else $error("link data moved while link clock high");
  a_latch_alone: assert property (cable_amp_link.latch |-> !cable_amp_link.clk)
    else $error("latch and link clock high together");
  a_high_phase: assert property ($fell(cable_amp_link.clk) |-> hi_cnt == LINK_HALF)
    else $error("link clock high phase of wrong length");
  a_latch_width: assert property ($fell(cable_amp_link.latch) |-> lat_cnt == LINK_HALF)
    else $error("latch strobe of wrong length");
  a_eight_bits: assert property ($rose(cable_amp_link.latch) |-> rise_cnt == 4'h8)
    else $error("latch not after eight link bits");
  a_profile_pin: assert property (profile_pin && $past(profile_pin) && $past(profile_pin, 2) && clk_en
    && $past(clk_en) && $past(clk_en, 2) && $past(nrst, 3) |-> tx_cfg.profile_active)
    else $error("profile pin high but profile one not active");
  a_freeze_hold: assert property (!clk_en |=> $stable(carrier_tuning_word) && $stable(cable_amp_link)
    && $stable(tx_cfg))
    else $error("outputs moved while clock enable low");

  c_latch: cover property ($rose(cable_amp_link.latch));
  c_profile: cover property ($rose(tx_cfg.profile_active));
  c_read_one: cover property ($rose(ctrl_sdo));
endmodule : front_end_checker

bind front_end_control_registers front_end_checker #(.LINK_HALF(LINK_HALF)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .ctrl_cs_n(ctrl_cs_n), .ctrl_sdo(ctrl_sdo),
  .profile_pin(profile_pin), .clamp_offset(clamp_offset), .tx_cfg(tx_cfg),
  .carrier_tuning_word(carrier_tuning_word), .cable_amp_link(cable_amp_link));

// file: host_port_model.sv
`timescale 1ns/1ps
module host_port_model (
  input  wire logic ref_clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  int stretch = 0;  // Extra cycles per phase, for a slow host

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi  = 1'b0;
  end

  // One whole frame: instruction byte, then data byte, MSB first
  task automatic frame(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {rd, 2'b00, a, d};
    q = 8'h00;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi  <= w[i];
      sclk <= 1'b0;
      // Low phase long enough for read data to settle
      repeat (3 + stretch) @(posedge ref_clk);
      if (i < 8) q[i] = sdo;
      sclk <= 1'b1;
      repeat (2 + stretch) @(posedge ref_clk);
    end
    sclk <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cs_n <= 1'b1;
    sdi  <= ~w[0];  // Released line shows no stale bit
    repeat (2) @(posedge ref_clk);
  endtask : frame
endmodule : host_port_model

// file: front_end_control_registers_tb_top.sv
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module front_end_control_registers_tb_top
  import front_end_pkg::*;
;
  localparam logic [3:0] DV = 4'h9;  // Arbitrary die version
  logic            ref_clk = 1'b0;
  logic            nrst = 1'b0;
  logic            clk_en = 1'b1;
  logic            profile_pin = 1'b0;
  wire             cs_n, sclk, sdi;
  logic            sdo, sigma_delta_out, general_flag_output;
  logic [7:0]      section_power_down;
  logic [10:0]     clamp_offset;
  rx_cfg_t         rx_cfg;
  tx_cfg_t         tx_cfg;
  logic [25:0]     carrier_tuning_word;
  logic [3:0]      dac_fine_gain;
  cable_amp_link_t cable_amp_link, lk_prev;
  logic [7:0]      sh [0:31];       // Expected register contents
  logic [7:0]      exp_q [$];       // Expected link words
  logic [7:0]      last_g, lk_sh, lk_exp;
  logic            last_p;
  logic [4:0]      addrs [17] = '{2, 3, 4, 5, 7, 8, 13, 14, 15, 16, 17, 18, 19, 20, 21, 22, 23};
  int              bad_count = 0;
  int              tests_run = 0;
  int              seed = 18416;

  always #4 ref_clk = ~ref_clk;

  // Short link phases keep the run brief
  front_end_control_registers #(.DIE_VERSION(DV), .LINK_HALF(1)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .ctrl_cs_n(cs_n), .ctrl_sclk(sclk), .ctrl_sdi(sdi),
    .ctrl_sdo(sdo), .profile_pin(profile_pin), .section_power_down(section_power_down),
    .sigma_delta_out(sigma_delta_out), .general_flag_output(general_flag_output), .clamp_offset(clamp_offset),
    .rx_cfg(rx_cfg), .tx_cfg(tx_cfg), .carrier_tuning_word(carrier_tuning_word),
    .dac_fine_gain(dac_fine_gain), .cable_amp_link(cable_amp_link));
  host_port_model host (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  // Writable bits of each offset; zero marks read-only or unmapped offsets below 5'h10
  function automatic logic [7:0] mask_of(input logic [4:0] a);
    case (a)
      5'h02, 5'h04: return 8'hFF;
      5'h03: return 8'h03;
      5'h05, 5'h0D, 5'h0E: return 8'h0F;
      5'h07: return 8'h7F;
      5'h08: return 8'hBB;
      5'h0F: return 8'h2F;
      default: return (a >= 5'h10) ? 8'hFF : 8'h00;
    endcase
  endfunction : mask_of

  // Word on the cable link for a gain byte
  function automatic logic [7:0] link_word(input logic [7:0] g, input logic m);
    if (!m) return g;
    if (g[7:4] == 4'h0 || g[7:4] > 4'h8) return 8'h00;
    return 8'h01 << (g[7:4] - 4'h1);
  endfunction : link_word

  // Outputs other than the link and read data, derived from the expected registers
  task automatic check_all();
    logic       act;
    logic [7:0] g;
    act = sh[15][5] | profile_pin;
    g = act ? sh[23] : sh[19];
    `CHECK_EQ(section_power_down, sh[2])
    `CHECK_EQ(general_flag_output, sh[3][1])
    if (sh[3][0]) `CHECK_EQ(sigma_delta_out, sh[4][7])
    `CHECK_EQ(clamp_offset, {sh[7][6:0], 4'h0})
    `CHECK_EQ(rx_cfg, {sh[8][0], sh[8][1], sh[8][3], sh[8][4], sh[8][5], sh[8][7]})
    `CHECK_EQ(tx_cfg, {sh[15][0], sh[15][1], sh[15][2], sh[15][3], act})
    `CHECK_EQ(carrier_tuning_word, act ? {sh[22], sh[21], sh[20], sh[13][3:2]} : {sh[18], sh[17], sh[16], sh[13][1:0]})
    `CHECK_EQ(dac_fine_gain, sh[15][3] ? g[3:0] : sh[14][3:0])
  endtask : check_all

  // A new active gain or profile means one more word on the link
  task automatic note_link();
    logic       act;
    logic [7:0] g;
    act = sh[15][5] | profile_pin;
    g = act ? sh[23] : sh[19];
    if (g !== last_g || act !== last_p) begin
      exp_q.push_back(link_word(g, sh[15][3]));
      last_g = g;
      last_p = act;
    end
  endtask : note_link

  task automatic put(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.frame(1'b0, a, d, q);
    sh[a] = d & mask_of(a);
    repeat (2) @(posedge ref_clk);
    note_link();
    check_all();
  endtask : put

  task automatic rchk(input logic [4:0] a);
    logic [7:0] q;
    host.frame(1'b1, a, 8'h00, q);
    `CHECK_EQ(q, (a == 5'h0C) ? {4'h0, DV} : sh[a])
  endtask : rchk

  task automatic pin(input logic v);
    profile_pin <= v;
    repeat (3) @(posedge ref_clk);
    note_link();
    check_all();
  endtask : pin

  // Link monitor: bits taken at clock rise, word judged at latch
  always @(posedge ref_clk) begin
    lk_prev <= cable_amp_link;
    if (cable_amp_link.clk && !lk_prev.clk) lk_sh <= {lk_sh[6:0], cable_amp_link.data};
    if (cable_amp_link.latch && !lk_prev.latch) begin
      `CHECK_EQ(exp_q.size() != 0, 1'b1)
      if (exp_q.size() != 0) begin
        lk_exp = exp_q.pop_front();
        `CHECK_EQ(lk_sh, lk_exp)
      end
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well beyond the longest expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    $display("test watchdog expired");
    tally_and_finish();
  end

  initial begin
    logic [4:0] a;
    logic [7:0] d;
    int         r;
    foreach (sh[i]) sh[i] = 8'h00;
    sh[7] = 8'h20;
    last_g = 8'h00;
    last_p = 1'b0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check_all();
    for (int i = 0; i < 32; i++) rchk(i[4:0]);  // Reset values and unmapped reads
    $display("test reset_values done");
    put(5'h0F, 8'h08);
    for (int c = 0; c < 16; c++) put(5'h13, {c[3:0], 4'hA});
    put(5'h0F, 8'h00);
    put(5'h17, 8'h5C);
    pin(1'b1);
    pin(1'b0);
    put(5'h09, 8'hFF);
    rchk(5'h09);
    put(5'h03, 8'h01);
    put(5'h04, 8'h80);
    put(5'h04, 8'h7F);
    $display("test directed done");
    for (int n = 0; n < 60; n++) begin
      r = $random(seed);
      a = addrs[r[7:0] % 17];
      d = $random(seed);
      if (a == 5'h07) d = 8'h16 + d % 8'h6A;
      if (a == 5'h0F) d[5] = d[5] & ~profile_pin;
      put(a, d & mask_of(a));
      rchk(a);
      if (r[8] && !sh[15][5]) pin(r[9]);
      // Short freeze between frames
      if (r[10]) begin
        clk_en <= 1'b0;
        repeat (4) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
      host.stretch = r[12:11];
    end
    $display("test random done");
    repeat (40) @(posedge ref_clk);
    `CHECK_EQ(exp_q.size(), 0)
    tally_and_finish();
  end
endmodule : front_end_control_registers_tb_top
